// ---- logic/saci_pkg.sv ----
// Constants, types and helpers shared by the serial converter control block.
// Assumes one core clock; all pins are sampled and their edges found in its cycles.
// Behaviour
// - Serial port works only while select is low.
// - Bits launch on falling shift clock edges, are sampled on rising ones.
// - Config in and result out move together on the same edges.
// - First eight rising edges after recognised select capture config.
// - Further serial input bits are ignored until the next exchange begins.
// - Previous conversion result shifts out while the config word shifts in.
// - Exchange end starts the conversion; host then raises select.
// - Finished result is held and sent on the next exchange.
// - Arrival: single/diff, odd, select x2, unipolar, msb-first, length x2.
// - First four config bits route the multiplexer for that conversion.
// - Differential mode measures one of four adjacent pairs, any polarity.
// - Single-ended mode measures a channel against the common input.
// - Select bits choose the differential pair; odd/sign picks positive.
// - Single-ended positive channel is twice select plus odd/sign.
// - Result leaves on serial output and the register bus, config enters only on input.
// - Conversion timed by conversion clock, transfers by shift clock.
// - After select falls, wait two falling conversion clock edges.
// - Unipolar flag one gives unipolar code, zero gives two's complement.
// - Msb-first flag sets only the bit order of the next output word.
// - Word length bits set present output length: 8, 10, 12 or 16.
package saci_pkg;
    localparam int CFG_BITS = 8;
    localparam int RES_BITS = 10;
    // Config word field positions, first arriving bit at the top
    localparam int F_SGL = 7;
    localparam int F_ODD = 6;
    localparam int F_SEL_HI = 5;
    localparam int F_SEL_LO = 4;
    localparam int F_UNIPOLAR = 3;
    localparam int F_MSB_FIRST = 2;
    localparam int F_WL_HI = 1;
    localparam int F_WL_LO = 0;
    // Output word lengths in shift clocks
    localparam logic [4:0] WL_8 = 5'h08;
    localparam logic [4:0] WL_10 = 5'h0a;
    localparam logic [4:0] WL_12 = 5'h0c;
    localparam logic [4:0] WL_16 = 5'h10;
    localparam logic [4:0] CNT_SAT = 5'h1f;
    // Conversion clock timing
    localparam logic [1:0] ARM_LAST = 2'h1;
    localparam int CONV_ACLK_CYCLES = 44;
    // Register bus map
    localparam int ADDR_W = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_RESULT = 4'h8;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RESET = 1'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARM = 2'b01,
        ST_XFER = 2'b10,
        ST_CONV = 2'b11
    } saci_state_type;

    // Output word length from the two length bits
    function automatic logic [4:0] wordLen(input logic [7:0] cfg);
        case ({cfg[F_WL_HI], cfg[F_WL_LO]})
            2'b00: wordLen = WL_8;
            2'b01: wordLen = WL_10;
            2'b10: wordLen = WL_12;
            default: wordLen = WL_16;
        endcase
    endfunction

    // Bit of the result sent at a given position; zeros pad long words
    function automatic logic pickBit(input logic [9:0] res,
            input logic [4:0] idx, input logic msbFirst);
        if (idx >= 5'(RES_BITS))
            pickBit = 1'b0;
        else if (msbFirst)
            pickBit = res[4'(RES_BITS - 1) - idx[3:0]];
        else
            pickBit = res[idx[3:0]];
    endfunction

    // Unipolar keeps straight binary; bipolar flips to two's complement
    function automatic logic [9:0] fmtCode(input logic [9:0] code,
            input logic unipolar);
        fmtCode = unipolar ? code : {~code[9], code[8:0]};
    endfunction
endpackage

// ---- logic/saci_sync.sv ----
// Two flip-flop synchroniser for pins from outside the core clock domain.
// Assumes the inputs are asynchronous levels; output is safe to read.
`timescale 1ns/1ns
module saci_sync #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            meta_q <= '0;
            syncOut <= '0;
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule // saci_sync

// ---- logic/saci_mux.sv ----
// Multiplexer routing decode for the requested conversion.
// Assumes load pulses once per accepted config word.
`timescale 1ns/1ns
module saci_mux
    import saci_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [3:0] muxAddr,
    output logic [2:0] muxPos,
    output logic [2:0] muxNeg,
    output logic muxNegCom
);
    logic [2:0] pos;

    assign pos = {muxAddr[1:0], muxAddr[2]};

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            muxPos <= 3'h0;
            muxNeg <= 3'h1;
            muxNegCom <= 1'b0;
        end else if (load) begin
            muxPos <= pos;
            muxNeg <= pos ^ 3'h1;
            muxNegCom <= muxAddr[3];
        end
    end
endmodule // saci_mux

// ---- logic/saci_top.sv ----
// Serial converter control: pin sampling, config capture, result shift
// out, conversion timing and an AXI4-Lite register slave.
// Assumes pins are asynchronous to core_clk and much slower than it.
`timescale 1ns/1ns
module saci_top
    import saci_pkg::*;
#(
    parameter int CONV_CLKS = CONV_ACLK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic csN,
    input wire logic sclk,
    input wire logic din,
    input wire logic aclk,
    input wire logic [9:0] analogCode,
    output logic dout,
    output logic doutOe,
    output logic [2:0] muxPos,
    output logic [2:0] muxNeg,
    output logic muxNegCom,
    output logic unipolarFlag,
    output logic convBusy,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam logic [5:0] CONV_LAST = 6'(CONV_CLKS - 1);

    logic [3:0] pinS;
    logic [3:0] pinD_q;
    logic csLow;
    logic dinS;
    logic sclkRise;
    logic sclkFall;
    logic aclkFall;
    saci_state_type state_q;
    logic [1:0] armCnt_q;
    logic [5:0] convCnt_q;
    logic [4:0] inCnt_q;
    logic [4:0] riseCnt_q;
    logic [4:0] outIdx_q;
    logic [7:0] cfg_q;
    logic wordIn;
    logic xferEnd;
    logic convStart;
    logic convDone;
    logic pendMsbFirst_q;
    logic [9:0] result_q;
    logic outMsbFirst_q;
    logic portEn_q;
    logic [ADDR_W-1:0] awAddr_q;
    logic awHeld_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic wHeld_q;
    logic [31:0] rdData_d;
    logic rdOk_d;

    // Pins pass two flip-flops; select enters inverted so reset reads idle
    saci_sync #(.W(4)) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .asyncIn({!csN, sclk, din, aclk}),
        .syncOut(pinS)
    );

    // Previous synchronised level for edge finding
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            pinD_q <= 4'h0; // Matches synchroniser reset: no false edges
        else
            pinD_q <= pinS;
    end

    assign csLow = pinS[3];
    assign dinS = pinS[1];
    assign sclkRise = pinS[2] && !pinD_q[2];
    assign sclkFall = !pinS[2] && pinD_q[2];
    assign aclkFall = !pinS[0] && pinD_q[0];

    // Exchange status terms
    assign wordIn = (inCnt_q == 5'(CFG_BITS));
    // present word length ends the exchange
    assign xferEnd = wordIn && (riseCnt_q >= wordLen(cfg_q));
    assign convStart = (state_q == ST_XFER) && wordIn && (!csLow || xferEnd);
    assign convDone = (state_q == ST_CONV) && aclkFall
        && (convCnt_q == CONV_LAST);

    // Main sequence of a select cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (csLow && portEn_q)
                        state_q <= ST_ARM;
                end
                ST_ARM: begin
                    if (!csLow)
                        state_q <= ST_IDLE;
                    else if (aclkFall && armCnt_q == ARM_LAST)
                        state_q <= ST_XFER;
                end
                ST_XFER: begin
                    if (convStart)
                        state_q <= ST_CONV;
                    else if (!csLow)
                        state_q <= ST_IDLE;
                end
                ST_CONV: begin
                    if (convDone)
                        state_q <= csLow ? ST_XFER : ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Deglitch wait counter
    always_ff @(posedge core_clk) begin
        if (!rst_n || state_q != ST_ARM)
            armCnt_q <= 2'h0;
        else if (aclkFall)
            armCnt_q <= armCnt_q + 2'h1;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || state_q != ST_CONV)
            convCnt_q <= 6'h0;
        else if (aclkFall)
            convCnt_q <= convCnt_q + 6'h1;
    end

    // Bit counters, cleared between exchanges
    always_ff @(posedge core_clk) begin
        if (!rst_n || state_q == ST_IDLE || convDone) begin
            inCnt_q <= 5'h0;
            riseCnt_q <= 5'h0;
            outIdx_q <= 5'h0;
        end else if (state_q == ST_XFER) begin
            if (sclkRise && riseCnt_q != CNT_SAT)
                riseCnt_q <= riseCnt_q + 5'h1;
            if (sclkRise && !wordIn)
                inCnt_q <= inCnt_q + 5'h1;
            if (sclkFall && outIdx_q != CNT_SAT)
                outIdx_q <= outIdx_q + 5'h1;
        end
    end

    // Config word shift register
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            cfg_q <= 8'h00;
        else if (state_q == ST_XFER && sclkRise && !wordIn)
            cfg_q <= {cfg_q[6:0], dinS};
    end

    // Settings carried with the requested conversion
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            unipolarFlag <= 1'b1;
            pendMsbFirst_q <= 1'b1;
        end else if (convStart) begin
            unipolarFlag <= cfg_q[F_UNIPOLAR];
            pendMsbFirst_q <= cfg_q[F_MSB_FIRST];
        end
    end

    // Hold the finished result and its bit order
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            result_q <= 10'h000;
            outMsbFirst_q <= 1'b1;
        end else if (convDone) begin
            result_q <= fmtCode(analogCode, unipolarFlag);
            outMsbFirst_q <= pendMsbFirst_q;
        end
    end

    // Multiplexer routing for the requested conversion
    saci_mux u_mux (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .load(convStart),
        .muxAddr(cfg_q[F_SGL:F_SEL_LO]),
        .muxPos(muxPos),
        .muxNeg(muxNeg),
        .muxNegCom(muxNegCom)
    );

    // Serial output pin and busy flag
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dout <= 1'b0;
            doutOe <= 1'b0;
            convBusy <= 1'b0;
        end else begin
            doutOe <= (state_q == ST_XFER);
            dout <= (state_q == ST_XFER)
                ? pickBit(result_q, outIdx_q, outMsbFirst_q) : 1'b0;
            convBusy <= (state_q == ST_CONV);
        end
    end

    // Write channel: address and data taken in either order
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= '0;
            wData_q <= 32'h0;
            wStrb_q <= 4'h0;
            portEn_q <= CTRL_EN_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr_q <= s_axi_awaddr;
                awHeld_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
                wHeld_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (awHeld_q && wHeld_q && !s_axi_bvalid) begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awAddr_q == REG_CTRL) begin
                    s_axi_bresp <= RESP_OKAY;
                    if (wStrb_q[0])
                        portEn_q <= wData_q[CTRL_EN_BIT];
                end else begin
                    s_axi_bresp <= (awAddr_q == REG_STATUS
                        || awAddr_q == REG_RESULT) ? RESP_OKAY
                        : RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read decode
    always_comb begin
        rdData_d = 32'h0;
        rdOk_d = 1'b1;
        case (s_axi_araddr)
            REG_CTRL: rdData_d[CTRL_EN_BIT] = portEn_q;
            REG_STATUS: rdData_d[12:0] = {convBusy, outMsbFirst_q, 1'b0,
                state_q, cfg_q};
            REG_RESULT: rdData_d[9:0] = result_q;
            default: rdOk_d = 1'b0;
        endcase
    end

    // Read channel
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdData_d;
            s_axi_rresp <= rdOk_d ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_DESELECT_HIZ: assert property (
        !pinD_q[3] |=> !doutOe)
        else $error("serial output driven while deselected");

    AST_ARM_TWO_FALLS: assert property (
        (state_q == ST_XFER && $past(state_q) == ST_ARM)
        |-> ($past(armCnt_q) == ARM_LAST && $past(aclkFall)))
        else $error("exchange opened before two conversion clock falls");

    AST_CAPTURE_BIT: assert property (
        (state_q == ST_XFER && sclkRise && !wordIn && csLow)
        |=> (cfg_q[0] == $past(dinS)
            && inCnt_q == $past(inCnt_q) + 5'h1))
        else $error("config bit not captured on rising edge");

    AST_IGNORE_DIN: assert property (
        (state_q == ST_XFER && wordIn) |=> $stable(cfg_q))
        else $error("config changed after eight bits");

    AST_END_STARTS: assert property (
        (state_q == ST_XFER && xferEnd) |=> state_q == ST_CONV ##1 convBusy)
        else $error("conversion not started at exchange end");

    AST_CONV_LENGTH: assert property (
        ($past(state_q) == ST_CONV && state_q != ST_CONV)
        |-> ($past(convCnt_q) == CONV_LAST && $past(aclkFall)))
        else $error("conversion length wrong");

    AST_RESULT_HELD: assert property (
        convDone |=> result_q == fmtCode($past(analogCode), unipolarFlag))
        else $error("finished result not held");

    AST_MUX_POS: assert property (
        convStart |=> muxPos == {$past(cfg_q[F_SEL_HI]),
            $past(cfg_q[F_SEL_LO]), $past(cfg_q[F_ODD])})
        else $error("positive channel wrong");

    AST_MUX_DIFF: assert property (
        (convStart && !cfg_q[F_SGL])
        |=> (!muxNegCom && muxNeg == (muxPos ^ 3'h1)))
        else $error("differential pair wrong");

    AST_DOUT_ORDER: assert property (
        (state_q == ST_XFER && outIdx_q == 5'h0)
        |=> dout == (outMsbFirst_q ? result_q[RES_BITS-1] : result_q[0]))
        else $error("first output bit in wrong order");
endmodule // saci_top

// ---- dv/saci_host_model.sv ----
// Host end of the serial link: select, shift clock and config bits.
// Assumes core_clk paces it; shift clock is 6 low and 2 high core cycles.
`timescale 1ns/1ns
module saci_host_model (
    input wire logic core_clk,
    input wire logic dout,
    input wire logic doutOe,
    output logic csN,
    output logic sclk,
    output logic din,
    output logic [15:0] rxWord,
    output logic rxStrobe
);
    // Idle link levels
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        din = 1'b1;
        rxWord = 16'h0000;
        rxStrobe = 1'b0;
    end

    // One full-duplex transfer of nbits shift clocks
    task automatic exchange(input logic [7:0] cfg, input int nbits);
        logic [15:0] w;
        w = 16'h0000;
        @(posedge core_clk);
        csN <= 1'b0;
        // Clock only once the device drives; the bench watchdog ends hangs
        while (doutOe !== 1'b1)
            @(posedge core_clk);
        for (int i = 0; i < nbits; i++) begin
            // launch while low, sample at rise
            din <= (i < 8) ? cfg[7 - i] : ~din;
            repeat (6) @(posedge core_clk);
            sclk <= 1'b1;
            w[i] = doutOe ? dout : 1'bz;
            repeat (2) @(posedge core_clk);
            sclk <= 1'b0;
        end
        // select back high after the word
        @(posedge core_clk);
        csN <= 1'b1;
        din <= ~din;
        rxWord <= w;
        rxStrobe <= 1'b1;
        @(posedge core_clk);
        rxStrobe <= 1'b0;
    endtask
endmodule // saci_host_model

// ---- dv/saci_top_test.sv ----
// Self-checking bench for the serial converter control block.
// Assumes the host model in the same folder and a 25 MHz core clock.
`timescale 1ns/1ns
module saci_top_test
    import saci_pkg::*;
;
    logic core_clk, rst_n, aclk, csN, sclk, din, dout, doutOe, rxStrobe;
    logic muxNegCom, unipolarFlag, convBusy, prevBusy;
    logic [2:0] muxPos, muxNeg;
    logic [9:0] analogCode, heldRes;
    logic [15:0] rxWord;
    logic [3:0] awaddr, araddr, wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, heldMsbFirst;
    logic [31:0] wdata, rdata, rnd;
    logic [1:0] bresp, rresp;
    logic [65:0] rdQ[$];
    logic [1:0] bQ[$];
    logic [15:0] wordQ[$];
    logic [4:0] muxQ[$];
    logic [7:0] cfg;
    int numErrors = 0;
    int checked = 0;
    int csHigh = 0;

    saci_top #(.CONV_CLKS(4)) DUT (.core_clk(core_clk), .rst_n(rst_n),
        .csN(csN), .sclk(sclk), .din(din), .aclk(aclk),
        .analogCode(analogCode), .dout(dout), .doutOe(doutOe),
        .muxPos(muxPos), .muxNeg(muxNeg), .muxNegCom(muxNegCom),
        .unipolarFlag(unipolarFlag), .convBusy(convBusy),
        .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    saci_host_model HOST (.core_clk(core_clk), .dout(dout),
        .doutOe(doutOe), .csN(csN), .sclk(sclk), .din(din),
        .rxWord(rxWord), .rxStrobe(rxStrobe));

    // Core clock and a free conversion clock off the core edges
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        aclk = 1'b1;
        #7;
        forever #100 aclk = ~aclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Bits the host should see, first received at bit 0
    function automatic logic [15:0] expWord(input logic [9:0] r,
            input logic msbFirst, input int n);
        expWord = 16'h0000;
        for (int i = 0; i < n && i < 10; i++)
            expWord[i] = msbFirst ? r[9 - i] : r[i];
    endfunction

    task automatic chk(input string what, input logic [31:0] e,
            input logic [31:0] g);
        checked++;
        if (g !== e) begin
            numErrors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic reportAndStop();
        // Every note taken must have met its result
        chk("pending notes", 32'h0, 32'(wordQ.size() + muxQ.size()
            + rdQ.size() + bQ.size()));
        $display("comparisons %0d mismatches %0d", checked, numErrors);
        if (numErrors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic axiWrite(input logic [3:0] a, input logic [31:0] d,
            input logic [1:0] er);
        bQ.push_back(er);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask

    task automatic axiRead(input logic [3:0] a, input logic [31:0] e,
            input logic [31:0] m, input logic [1:0] er);
        rdQ.push_back({er, m, e});
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask

    // Drive one exchange and note what it must return
    task automatic doExchange(input logic [7:0] c, input int n);
        logic [9:0] code;
        rnd = lfsr(rnd);
        code = rnd[9:0];
        @(posedge core_clk);
        analogCode <= code;
        wordQ.push_back(expWord(heldRes, heldMsbFirst, n));
        if (n >= 8) muxQ.push_back({c[7], c[5:4], c[6], c[3]});
        HOST.exchange(c, n);
        repeat (60) @(posedge core_clk);
        if (n >= 8) begin
            heldRes = c[3] ? code : {~code[9], code[8:0]};
            heldMsbFirst = c[2];
        end
    endtask

    // Watches outputs and takes the oldest note off each queue
    always @(posedge core_clk) begin
        prevBusy <= convBusy;
        csHigh <= csN ? csHigh + 1 : 0;
        if (csHigh > 6 && doutOe !== 1'b0)
            chk("idle enable", 32'h0, 32'(doutOe));
        if (rxStrobe)
            chk("word", 32'(wordQ.pop_front()), 32'(rxWord));
        if (bvalid && bready)
            chk("bresp", 32'(bQ.pop_front()), 32'(bresp));
        if (rvalid && rready) begin
            chk("rdata", rdQ[0][31:0], rdata & rdQ[0][63:32]);
            chk("rresp", 32'(rdQ[0][65:64]), 32'(rresp));
            void'(rdQ.pop_front());
        end
        if (prevBusy === 1'b1 && convBusy === 1'b0) begin
            chk("pos", 32'(muxQ[0][3:1]), 32'(muxPos));
            chk("com", 32'(muxQ[0][4]), 32'(muxNegCom));
            chk("unipolar", 32'(muxQ[0][0]), 32'(unipolarFlag));
            if (!muxQ[0][4])
                chk("neg", 32'(muxQ[0][3:1] ^ 3'h1), 32'(muxNeg));
            void'(muxQ.pop_front());
        end
    end

    // Hang guard
    initial begin
        repeat (30000) @(posedge core_clk);
        numErrors++;
        reportAndStop();
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        analogCode = 10'h000;
        {awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready, prevBusy} = '0;
        wstrb = 4'hf;
        rnd = 32'hdec04104;
        heldRes = 10'h000;
        heldMsbFirst = 1'b1;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        axiRead(REG_CTRL, 32'h1, 32'h1, RESP_OKAY);
        axiRead(4'hc, 32'h0, 32'hffffffff, RESP_SLVERR);
        axiWrite(4'hc, 32'h1, RESP_SLVERR);
        axiWrite(REG_CTRL, 32'h0, RESP_OKAY);
        axiRead(REG_CTRL, 32'h0, 32'h1, RESP_OKAY);
        axiWrite(REG_CTRL, 32'h1, RESP_OKAY);
        axiWrite(REG_RESULT, 32'h3ff, RESP_OKAY);
        axiRead(REG_RESULT, 32'h0, 32'h3ff, RESP_OKAY);
        $display("test registers done");
        for (int k = 0; k < 16; k++) begin
            rnd = lfsr(rnd);
            cfg = {k[3:0], rnd[5:4], k[1:0] ^ k[3:2]};
            doExchange(cfg,
                cfg[1] ? (cfg[0] ? 16 : 12) : (cfg[0] ? 10 : 8));
            axiRead(REG_STATUS, {20'h0, cfg[2], 3'h0, cfg},
                32'h1bff, RESP_OKAY);
            axiRead(REG_RESULT, 32'(heldRes),
                32'h3ff, RESP_OKAY);
        end
        $display("test channel sweep done");
        doExchange(8'h3b, 4);
        doExchange(8'hd4, 8);
        $display("test short frame done");
        reportAndStop();
    end
endmodule // saci_top_test
